// ===== design/lcdr_ctrl.sv
`default_nettype none
// Contract
// - eight byte banks plus one icon bit bank
// - addresses X 0..127, bank 0..8
// - horizontal mode: X increments, wraps, bank advances
// - vertical mode: bank increments, wraps, X advances
// - column mirror puts X zero at right
// - after last address pointers return to origin
// - bit order picks MSB top or bottom
// - row mirror scans rows 63 down to 0, or 63 down to 32 in reduced mux
// - pad flips reverse near and far sub-blocks
// - reduced mux drives only bank 4-7 rows
// - icon row always scanned last
// - reduced mux turns bank 0-3 rows into columns
// - select low command, high memory data
// - init pin resets registers, aborts transfer
// - reset clears config, pointers; enters sleep
// - sleep grounds outputs, stops generators, keeps memory
// - pump factor 2X to 5X, reset 2X
module lcdr_ctrl #(
  parameter int unsigned STEP_DIV = lcdr_pkg::STEP_DIV_DEFAULT // sys_clk cycles per scan step
) (
  input wire logic sys_clk,           // 20 MHz clock
  input wire logic sys_rst,           // synchronous reset, high
  input wire logic chip_init_pin_n,   // chip init pin, low resets
  input wire logic byte_valid,        // one byte from the bus block
  input wire logic data_cmd_sel,      // high data, low command
  input wire logic [7:0] byte_in,     // byte value
  output logic [6:0] x_ptr,           // horizontal pointer
  output logic [3:0] y_ptr,           // bank pointer
  output logic sleep_state,           // power down
  output logic vertical_addr,         // vertical addressing
  output logic ext_set,               // extended instruction set
  output logic column_mirror,         // X zero on the right
  output logic row_scan_mirror,       // rows scanned bottom up
  output logic near_edge_pad_flip,    // near edge pad flip
  output logic far_edge_pad_flip,     // far edge pad flip
  output logic reduced_mux,           // 33 row operation
  output logic byte_msb_bottom,       // MSB at bottom pixel
  output logic [1:0] disp_mode,       // display mode bits
  output logic [1:0] temp_slope_sel,  // temperature slope
  output logic [2:0] bias_ratio_sel,  // bias ratio
  output logic pump_factor_msb,       // pump factor high bit
  output logic pump_factor_lsb,       // pump factor low bit
  output logic [2:0] pump_mult,       // pump factor 2..5
  output logic voltage_range_sel,     // voltage range
  output logic [6:0] vop_code,        // operating voltage code
  output logic osc_en,                // oscillator running
  output logic bias_gen_en,           // bias generator on
  output logic vlcd_gen_en,           // display voltage generator on
  output logic bank03_col_mode,       // bank 0-3 rows act as columns
  output logic px_out_valid,          // pixel strobe
  output logic px_out,                // pixel value, low in sleep
  output logic [6:0] px_out_col,      // pixel column
  output logic [6:0] px_out_drv       // pixel row driver
);
  import lcdr_pkg::*;

  localparam int unsigned DIV_W = $clog2(STEP_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_DIV - 1);

  lcdr_mem_if mif ();

  logic rst;
  logic cmd_stb;
  logic data_stb;
  logic [DIV_W-1:0] div_reg;
  logic step_en_reg;
  logic wr_en_reg;
  logic [3:0] wr_bank_reg;
  logic [6:0] wr_col_reg;
  logic [7:0] wr_data_reg;
  logic [6:0] x_next;
  logic [3:0] y_next;
  logic sc_valid;
  logic [6:0] sc_col;
  logic [6:0] sc_drv;
  logic [2:0] sc_bit_idx;
  logic sc_icon;
  logic [2:0] bit_sel;

  // either reset source resets every register but the memory array and its read data register and drops the byte in flight
  assign rst = sys_rst || !chip_init_pin_n;
  assign cmd_stb = byte_valid && !data_cmd_sel;
  assign data_stb = byte_valid && data_cmd_sel;

  // pointer advance after a data byte
  always_comb begin
    x_next = x_ptr;
    y_next = y_ptr;
    if (vertical_addr) begin
      if (y_ptr >= Y_LAST) begin
        y_next = RST_Y;
        x_next = (x_ptr == X_LAST) ? RST_X : x_ptr + 7'h01;
      end else begin
        y_next = y_ptr + 4'h1;
      end
    end else begin
      if (x_ptr == X_LAST) begin
        x_next = RST_X;
        y_next = (y_ptr >= Y_LAST) ? RST_Y : y_ptr + 4'h1;
      end else begin
        x_next = x_ptr + 7'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      x_ptr <= RST_X;
      y_ptr <= RST_Y;
    end else if (data_stb) begin
      x_ptr <= x_next;
      y_ptr <= y_next;
    end else if (cmd_stb) begin
      if (byte_in[7] && !ext_set) begin
        x_ptr <= byte_in[6:0];
      end else if (byte_in[7:4] == OP_SET_Y && byte_in[3:0] <= Y_LAST) begin
        // an out of range bank is ignored rather than aliased
        y_ptr <= byte_in[3:0];
      end
    end
  end

  // memory write, one cycle after the data byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_en_reg <= 1'b0;
      wr_bank_reg <= RST_Y;
      wr_col_reg <= RST_X;
      wr_data_reg <= 8'h00;
    end else begin
      wr_en_reg <= data_stb;
      wr_bank_reg <= y_ptr;
      wr_col_reg <= column_mirror ? X_LAST - x_ptr : x_ptr;
      wr_data_reg <= byte_in;
    end
  end

  assign mif.wr_en = wr_en_reg;
  assign mif.wr_bank = wr_bank_reg;
  assign mif.wr_col = wr_col_reg;
  assign mif.wr_data = wr_data_reg;

  // configuration commands
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sleep_state <= RST_SLEEP;
      vertical_addr <= 1'b0;
      ext_set <= 1'b0;
    end else if (cmd_stb && byte_in[7:3] == OP_FUNC) begin
      sleep_state <= byte_in[2];
      vertical_addr <= byte_in[1];
      ext_set <= byte_in[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      column_mirror <= 1'b0;
      row_scan_mirror <= 1'b0;
      near_edge_pad_flip <= 1'b0;
      far_edge_pad_flip <= 1'b0;
    end else if (cmd_stb && byte_in[7:4] == OP_MIRROR) begin
      column_mirror <= byte_in[3];
      row_scan_mirror <= byte_in[2];
      near_edge_pad_flip <= byte_in[1];
      far_edge_pad_flip <= byte_in[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reduced_mux <= 1'b0;
      byte_msb_bottom <= 1'b0;
    end else if (cmd_stb && byte_in[7:3] == OP_MUXFMT) begin
      reduced_mux <= byte_in[2];
      byte_msb_bottom <= byte_in[1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      temp_slope_sel <= RST_TEMP;
      bias_ratio_sel <= RST_BIAS;
      disp_mode <= RST_DISP;
      voltage_range_sel <= 1'b0;
    end else if (cmd_stb) begin
      if (byte_in[7:2] == OP_TEMP) begin
        temp_slope_sel <= byte_in[1:0];
      end else if (byte_in[7:3] == OP_BIAS) begin
        bias_ratio_sel <= byte_in[2:0];
      end else if (byte_in[7:2] == OP_DISP) begin
        disp_mode <= byte_in[1:0];
      end else if (byte_in[7:1] == OP_RANGE) begin
        voltage_range_sel <= byte_in[0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pump_factor_msb <= RST_PUMP[1];
      pump_factor_lsb <= RST_PUMP[0];
      pump_mult <= 3'h2;
    end else if (cmd_stb && byte_in[7:2] == OP_PUMP) begin
      pump_factor_msb <= byte_in[1];
      pump_factor_lsb <= byte_in[0];
      pump_mult <= {1'b0, byte_in[1:0]} + 3'h2;
    end
  end

  // voltage code shares the high opcode bit with X under the extended set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vop_code <= RST_VOP;
    end else if (cmd_stb && byte_in[7] && ext_set) begin
      vop_code <= byte_in[6:0];
    end
  end

  // analog enables, all off in sleep; bank 0-3 column mode follows reduced mux
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      osc_en <= 1'b0;
      bias_gen_en <= 1'b0;
      vlcd_gen_en <= 1'b0;
      bank03_col_mode <= 1'b0;
    end else begin
      osc_en <= !sleep_state;
      bias_gen_en <= !sleep_state;
      // range and code both zero keeps the generator off for an external supply
      vlcd_gen_en <= !sleep_state && (voltage_range_sel || vop_code != RST_VOP);
      bank03_col_mode <= reduced_mux;
    end
  end

  // scan pacing stands in for the display oscillator
  always_ff @(posedge sys_clk) begin
    if (rst || sleep_state) begin
      div_reg <= '0;
      step_en_reg <= 1'b0;
    end else begin
      step_en_reg <= (div_reg == DIV_LAST);
      div_reg <= (div_reg == DIV_LAST) ? '0 : div_reg + DIV_W'(1);
    end
  end

  lcdr_mem u_mem (
    .sys_clk(sys_clk),
    .mp(mif.mem)
  );

  lcdr_scan u_scan (
    .sys_clk(sys_clk),
    .rst(rst),
    .step_en(step_en_reg),
    .run(!sleep_state),
    .reduced_mux(reduced_mux),
    .row_scan_mirror(row_scan_mirror),
    .near_edge_pad_flip(near_edge_pad_flip),
    .far_edge_pad_flip(far_edge_pad_flip),
    .rp(mif.reader),
    .px_valid(sc_valid),
    .px_col(sc_col),
    .px_drv(sc_drv),
    .px_bit_idx(sc_bit_idx),
    .px_icon(sc_icon)
  );

  assign bit_sel = byte_msb_bottom ? sc_bit_idx : 3'h7 - sc_bit_idx;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      px_out_valid <= 1'b0;
      px_out <= 1'b0;
      px_out_col <= 7'h00;
      px_out_drv <= 7'h00;
    end else begin
      px_out_valid <= sc_valid && !sleep_state;
      px_out <= !sleep_state && sc_valid &&
                (sc_icon ? mif.rd_data[0] : mif.rd_data[bit_sel]);
      px_out_col <= sc_col;
      px_out_drv <= sc_drv;
    end
  end
endmodule : lcdr_ctrl
`default_nettype wire

// ===== inc/lcdr_pkg.sv
`default_nettype none
package lcdr_pkg;
  // memory geometry
  localparam int unsigned COLS = 128;
  localparam int unsigned BANKS = 9;
  localparam int unsigned MEM_DEPTH = 1152;
  localparam logic [6:0] X_LAST = 7'h7f;
  localparam logic [3:0] Y_LAST = 4'h8;
  localparam logic [3:0] ICON_BANK = 4'h8;
  // scan geometry
  localparam logic [6:0] ROWS_FULL = 7'h41;
  localparam logic [6:0] ROWS_REDUCED = 7'h21;
  localparam logic [6:0] ICON_ROW = 7'h40;
  localparam logic [6:0] GFX_LAST_ROW = 7'h3f;
  localparam logic [6:0] REDUCED_BASE = 7'h20;
  localparam logic [6:0] REDUCED_LAST = 7'h1f;
  localparam logic [6:0] FAR_EDGE_FIRST = 7'h20;
  localparam logic [6:0] SUB_BLOCK_MASK = 7'h0f;
  // command opcodes, matched on the upper bits
  localparam logic [4:0] OP_FUNC = 5'h04;   // 0010_0 sleep vert ext
  localparam logic [3:0] OP_MIRROR = 4'h1;  // 0001 cm rm nf ff
  localparam logic [4:0] OP_MUXFMT = 5'h01; // 0000_1 red msb x
  localparam logic [5:0] OP_TEMP = 6'h01;   // 0000_01 tt
  localparam logic [4:0] OP_BIAS = 5'h06;   // 0011_0 bbb
  localparam logic [5:0] OP_PUMP = 6'h0e;   // 0011_10 ss
  localparam logic [6:0] OP_RANGE = 7'h1e;  // 0011_110 r
  localparam logic [3:0] OP_SET_Y = 4'h4;   // 0100 yyyy
  localparam logic [5:0] OP_DISP = 6'h14;   // 0101_00 de
  // reset values
  localparam logic [6:0] RST_X = 7'h00;
  localparam logic [3:0] RST_Y = 4'h0;
  localparam logic [1:0] RST_PUMP = 2'h0;
  localparam logic [1:0] RST_TEMP = 2'h0;
  localparam logic [2:0] RST_BIAS = 3'h0;
  localparam logic [6:0] RST_VOP = 7'h00;
  localparam logic [1:0] RST_DISP = 2'h0;
  localparam logic RST_SLEEP = 1'b1;
  localparam int unsigned STEP_DIV_DEFAULT = 4;
endpackage : lcdr_pkg
`default_nettype wire

// ===== inc/lcdr_mem_if.sv
`default_nettype none
interface lcdr_mem_if;
  logic wr_en;
  logic [3:0] wr_bank;
  logic [6:0] wr_col;
  logic [7:0] wr_data;
  logic rd_en;
  logic [3:0] rd_bank;
  logic [6:0] rd_col;
  logic [7:0] rd_data;
  modport writer (output wr_en, output wr_bank, output wr_col, output wr_data);
  modport reader (output rd_en, output rd_bank, output rd_col, input rd_data);
  modport mem (input wr_en, input wr_bank, input wr_col, input wr_data,
               input rd_en, input rd_bank, input rd_col, output rd_data);
endinterface : lcdr_mem_if
`default_nettype wire

// ===== design/lcdr_mem.sv
`default_nettype none
module lcdr_mem (
  input wire logic sys_clk, // system clock
  lcdr_mem_if.mem mp        // write and read ports
);
  import lcdr_pkg::*;

  logic [7:0] mem_reg [MEM_DEPTH];
  logic [7:0] rd_data_reg;
  logic [10:0] wr_idx;
  logic [10:0] rd_idx;
  logic [7:0] wr_val;

  assign wr_idx = {mp.wr_bank, mp.wr_col};
  assign rd_idx = {mp.rd_bank, mp.rd_col};
  // icon bank keeps one bit per column
  assign wr_val = (mp.wr_bank == ICON_BANK) ? {7'h00, mp.wr_data[0]} : mp.wr_data;

  // no reset on the array: contents survive sleep and reset
  always_ff @(posedge sys_clk) begin
    if (mp.wr_en && mp.wr_bank <= ICON_BANK) begin
      mem_reg[wr_idx] <= wr_val;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (mp.rd_en) begin
      rd_data_reg <= mem_reg[rd_idx];
    end
  end

  assign mp.rd_data = rd_data_reg;
endmodule : lcdr_mem
`default_nettype wire

// ===== design/lcdr_scan.sv
`default_nettype none
module lcdr_scan (
  input wire logic sys_clk,         // system clock
  input wire logic rst,             // synchronous reset, high
  input wire logic step_en,         // one pixel step per pulse
  input wire logic run,             // low stops the scan
  input wire logic reduced_mux,     // 33 row operation
  input wire logic row_scan_mirror, // read rows bottom up
  input wire logic near_edge_pad_flip, // flip near edge sub-blocks
  input wire logic far_edge_pad_flip,  // flip far edge sub-blocks
  lcdr_mem_if.reader rp,            // memory read port
  output logic px_valid,            // pixel info valid with rd_data
  output logic [6:0] px_col,        // column of the pixel
  output logic [6:0] px_drv,        // row driver index
  output logic [2:0] px_bit_idx,    // row within its bank
  output logic px_icon              // pixel comes from icon bank
);
  import lcdr_pkg::*;

  logic [6:0] step_reg;
  logic [6:0] col_reg;
  logic [6:0] n_rows;
  logic [6:0] mem_row;
  logic [6:0] drv;
  logic last_step;

  assign n_rows = reduced_mux ? ROWS_REDUCED : ROWS_FULL;
  assign last_step = (step_reg == n_rows - 7'h01);

  always_comb begin
    mem_row = ICON_ROW;
    drv = ICON_ROW;
    if (!last_step) begin
      if (reduced_mux) begin
        mem_row = REDUCED_BASE + (row_scan_mirror ? REDUCED_LAST - step_reg : step_reg);
        drv = REDUCED_BASE + step_reg;
      end else begin
        mem_row = row_scan_mirror ? GFX_LAST_ROW - step_reg : step_reg;
        drv = step_reg;
      end
      if (drv < FAR_EDGE_FIRST && near_edge_pad_flip) begin
        drv = drv ^ SUB_BLOCK_MASK;
      end else if (drv >= FAR_EDGE_FIRST && far_edge_pad_flip) begin
        drv = drv ^ SUB_BLOCK_MASK;
      end
    end
  end

  // sleep restarts the frame so wake-up begins at the top row
  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      step_reg <= 7'h00;
      col_reg <= 7'h00;
    end else begin
      if (step_en) begin
        col_reg <= col_reg + 7'h01;
      end
      if (step_reg >= n_rows) begin
        // mux change mid frame could leave the step past the end, even with a step every cycle
        step_reg <= 7'h00;
      end else if (step_en && col_reg == X_LAST) begin
        step_reg <= last_step ? 7'h00 : step_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      px_valid <= 1'b0;
      px_col <= 7'h00;
      px_drv <= 7'h00;
      px_bit_idx <= 3'h0;
      px_icon <= 1'b0;
    end else begin
      px_valid <= step_en && run;
      px_col <= col_reg;
      px_drv <= drv;
      px_bit_idx <= mem_row[2:0];
      px_icon <= last_step;
    end
  end

  assign rp.rd_en = step_en && run;
  assign rp.rd_bank = mem_row[6:3];
  assign rp.rd_col = col_reg;
endmodule : lcdr_scan
`default_nettype wire

// ===== dv/lcdr_ctrl_properties.sv
`default_nettype none
module lcdr_ctrl_props #(
  parameter int unsigned STEP_DIV = 4 // scan divider, only passed on
) (
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // sync reset
  input wire logic chip_init_pin_n, // init pin
  input wire logic byte_valid, // byte strobe
  input wire logic data_cmd_sel, // data or command
  input wire logic [7:0] byte_in, // byte
  input wire logic [6:0] x_ptr, // x pointer
  input wire logic [3:0] y_ptr, // bank pointer
  input wire logic sleep_state, // power down
  input wire logic vertical_addr, // vertical mode
  input wire logic column_mirror, // col mirror
  input wire logic row_scan_mirror, // row mirror
  input wire logic near_edge_pad_flip, // near flip
  input wire logic far_edge_pad_flip, // far flip
  input wire logic reduced_mux, // 33 rows
  input wire logic pump_factor_msb, // pump high
  input wire logic pump_factor_lsb, // pump low
  input wire logic [2:0] pump_mult, // pump factor
  input wire logic voltage_range_sel, // range
  input wire logic [6:0] vop_code, // voltage code
  input wire logic osc_en, // oscillator
  input wire logic vlcd_gen_en, // generator
  input wire logic bank03_col_mode, // rows as columns
  input wire logic px_out_valid, // pixel strobe
  input wire logic px_out // pixel
);
  logic rst_any;
  logic data_in;
  logic vlcd_want;
  assign rst_any = sys_rst || !chip_init_pin_n;
  assign data_in = byte_valid && data_cmd_sel;
  assign vlcd_want = !sleep_state && (voltage_range_sel || vop_code != 7'h00);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst_any);
  ptr_hold_a: assert property (
    (!byte_valid || (!data_cmd_sel && !byte_in[7] && byte_in[7:4] != 4'h4))
    |=> $stable(x_ptr) && $stable(y_ptr)) else $error("pointer moved without data");
  horiz_step_a: assert property (
    data_in && !vertical_addr && x_ptr != 7'h7f |=> x_ptr == $past(x_ptr) + 7'h01 && $stable(y_ptr))
    else $error("horizontal step wrong");
  horiz_wrap_a: assert property (
    data_in && !vertical_addr && x_ptr == 7'h7f && y_ptr != 4'h8
    |=> x_ptr == 7'h00 && y_ptr == $past(y_ptr) + 4'h1) else $error("horizontal wrap wrong");
  vert_step_a: assert property (
    data_in && vertical_addr && y_ptr != 4'h8 |=> y_ptr == $past(y_ptr) + 4'h1 && $stable(x_ptr))
    else $error("vertical step wrong");
  vert_wrap_a: assert property (
    data_in && vertical_addr && y_ptr == 4'h8 && x_ptr != 7'h7f
    |=> y_ptr == 4'h0 && x_ptr == $past(x_ptr) + 7'h01) else $error("vertical wrap wrong");
  origin_wrap_a: assert property (
    data_in && x_ptr == 7'h7f && y_ptr == 4'h8 |=> x_ptr == 7'h00 && y_ptr == 4'h0)
    else $error("no return to origin");
  reset_state_a: assert property (disable iff (1'b0)
    rst_any |=> sleep_state && !vertical_addr && !column_mirror && x_ptr == 7'h00
    && y_ptr == 4'h0 && pump_mult == 3'h2 && vop_code == 7'h00) else $error("bad reset state");
  pump_map_a: assert property (
    pump_mult == 3'h2 + {1'b0, pump_factor_msb, pump_factor_lsb}) else $error("pump factor wrong");
  mirror_cmd_a: assert property (
    byte_valid && !data_cmd_sel && byte_in[7:4] == 4'h1
    |=> {column_mirror, row_scan_mirror, near_edge_pad_flip, far_edge_pad_flip}
    == $past(byte_in[3:0])) else $error("mirror command wrong");
  sleep_dark_a: assert property (
    sleep_state [*4] |-> !px_out_valid && !px_out && !osc_en && !vlcd_gen_en)
    else $error("activity in sleep");
  vlcd_tie_a: assert property (
    vlcd_gen_en == $past(vlcd_want)) else $error("generator enable wrong");
  bank_col_a: assert property (
    (reduced_mux && !sleep_state) [*2] |-> bank03_col_mode) else $error("bank rows not columns");
endmodule : lcdr_ctrl_props
bind lcdr_ctrl lcdr_ctrl_props #(.STEP_DIV(STEP_DIV)) props_i (.sys_clk, .sys_rst,
  .chip_init_pin_n, .byte_valid, .data_cmd_sel, .byte_in, .x_ptr, .y_ptr, .sleep_state,
  .vertical_addr, .column_mirror, .row_scan_mirror, .near_edge_pad_flip, .far_edge_pad_flip,
  .reduced_mux, .pump_factor_msb, .pump_factor_lsb, .pump_mult, .voltage_range_sel, .vop_code,
  .osc_en, .vlcd_gen_en, .bank03_col_mode, .px_out_valid, .px_out);
`default_nettype wire

// ===== dv/lcdr_host.sv
`default_nettype none
module lcdr_host (
  input wire logic sys_clk, // clock
  output logic byte_valid, // byte strobe
  output logic data_cmd_sel, // high data
  output logic [7:0] byte_in, // byte value
  output logic chip_init_pin_n // init pin, low resets
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    byte_valid = 1'b0;
    data_cmd_sel = 1'b0;
    byte_in = 8'h00;
    chip_init_pin_n = 1'b1;
  end
  // caller keeps pointers in range and places them itself in reduced mux
  task automatic put(input logic dc, input logic [7:0] b);
    @(posedge sys_clk);
    byte_valid <= 1'b1;
    data_cmd_sel <= dc;
    byte_in <= b;
    @(posedge sys_clk);
    byte_valid <= 1'b0;
    // released lines must not keep the last value
    data_cmd_sel <= ~dc;
    byte_in <= ~b;
  endtask : put
  task automatic init_pulse();
    @(posedge sys_clk);
    chip_init_pin_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chip_init_pin_n <= 1'b1;
  endtask : init_pulse
endmodule : lcdr_host
`default_nettype wire

// ===== dv/lcdr_ctrl_tb.sv
`default_nettype none
module lcdr_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic dc; logic [7:0] b; logic [3:0] f; logic [11:0] e;} lcdr_row_t;
  logic sys_clk, sys_rst, chip_init_pin_n, byte_valid, data_cmd_sel;
  logic [7:0] byte_in;
  logic [6:0] x_ptr, vop_code, px_out_col, px_out_drv;
  logic [3:0] y_ptr;
  logic sleep_state, vertical_addr, ext_set, column_mirror, row_scan_mirror, near_edge_pad_flip;
  logic far_edge_pad_flip, reduced_mux, byte_msb_bottom, pump_factor_msb, pump_factor_lsb;
  logic voltage_range_sel, osc_en, bias_gen_en, vlcd_gen_en, bank03_col_mode, px_out_valid, px_out;
  logic [1:0] disp_mode, temp_slope_sel;
  logic [2:0] bias_ratio_sel, pump_mult;
  int err_count = 0;
  int checked = 0;
  logic [11:0] rst_exp [0:11] = '{12'h004, 12'h000, 12'h000, 12'h000, 12'h000, 12'h002,
    12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000};
  lcdr_row_t rows [0:34] = '{{1'b0, 8'h23, 4'h0, 12'h003}, {1'b0, 8'hc2, 4'h8, 12'h042},
    {1'b0, 8'hc2, 4'ha, 12'h000}, {1'b0, 8'h3d, 4'h6, 12'h001}, {1'b0, 8'h20, 4'h0, 12'h000},
    {1'b0, 8'h1a, 4'h1, 12'h00a}, {1'b0, 8'h15, 4'h1, 12'h005}, {1'b0, 8'h0e, 4'h2, 12'h003},
    {1'b0, 8'h0a, 4'h2, 12'h001}, {1'b0, 8'h06, 4'h3, 12'h002}, {1'b0, 8'h35, 4'h4, 12'h005},
    {1'b0, 8'h38, 4'h5, 12'h002}, {1'b0, 8'h39, 4'h5, 12'h003}, {1'b0, 8'h3a, 4'h5, 12'h004},
    {1'b0, 8'h3b, 4'h5, 12'h005}, {1'b0, 8'h52, 4'h7, 12'h002}, {1'b0, 8'h3c, 4'h6, 12'h000},
    {1'b0, 8'h47, 4'h9, 12'h007}, {1'b0, 8'h49, 4'h9, 12'h007}, {1'b0, 8'h48, 4'h9, 12'h008},
    {1'b0, 8'hff, 4'ha, 12'h07f}, {1'b1, 8'h00, 4'hb, 12'h000}, {1'b1, 8'h00, 4'hb, 12'h010},
    {1'b0, 8'hff, 4'ha, 12'h07f}, {1'b0, 8'h43, 4'h9, 12'h003}, {1'b1, 8'h11, 4'hb, 12'h004},
    {1'b0, 8'h22, 4'h0, 12'h002}, {1'b0, 8'h47, 4'h9, 12'h007}, {1'b1, 8'h5a, 4'hb, 12'h008},
    {1'b1, 8'h5a, 4'hb, 12'h010}, {1'b0, 8'h48, 4'h9, 12'h008}, {1'b0, 8'hff, 4'ha, 12'h07f},
    {1'b1, 8'h5a, 4'hb, 12'h000}, {1'b0, 8'h00, 4'h9, 12'h000}, {1'b0, 8'h20, 4'h0, 12'h000}};
  lcdr_host host (.sys_clk, .byte_valid, .data_cmd_sel, .byte_in, .chip_init_pin_n);
  lcdr_ctrl #(.STEP_DIV(1)) DUT (.sys_clk, .sys_rst, .chip_init_pin_n, .byte_valid,
    .data_cmd_sel, .byte_in, .x_ptr, .y_ptr, .sleep_state, .vertical_addr, .ext_set,
    .column_mirror, .row_scan_mirror, .near_edge_pad_flip, .far_edge_pad_flip, .reduced_mux,
    .byte_msb_bottom, .disp_mode, .temp_slope_sel, .bias_ratio_sel, .pump_factor_msb,
    .pump_factor_lsb, .pump_mult, .voltage_range_sel, .vop_code, .osc_en, .bias_gen_en,
    .vlcd_gen_en, .bank03_col_mode, .px_out_valid, .px_out, .px_out_col, .px_out_drv);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  function automatic logic [11:0] field(input int f);
    case (f)
      0: field = {9'h000, sleep_state, vertical_addr, ext_set};
      1: field = {8'h00, column_mirror, row_scan_mirror, near_edge_pad_flip, far_edge_pad_flip};
      2: field = {10'h000, reduced_mux, byte_msb_bottom};
      3: field = {10'h000, temp_slope_sel};
      4: field = {9'h000, bias_ratio_sel};
      5: field = {9'h000, pump_mult};
      6: field = {11'h000, voltage_range_sel};
      7: field = {10'h000, disp_mode};
      8: field = {5'h00, vop_code};
      9: field = {8'h00, y_ptr};
      10: field = {5'h00, x_ptr};
      default: field = {1'b0, x_ptr, y_ptr};
    endcase
  endfunction : field
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  // bounded search for one pixel of the scan, then compare its value
  task automatic see_px(input logic [6:0] c, input logic [6:0] d, input logic e);
    int n;
    n = 0;
    repeat (8) @(posedge sys_clk);
    #1;
    while (!(px_out_valid === 1'b1 && px_out_col === c && px_out_drv === d) && n < 8500) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 8500) begin
      err_count++;
      $display("wrong value at %0t ns: pixel never seen", $time);
      give_verdict();
    end else begin
      chk({11'h000, px_out}, {11'h000, e});
    end
  endtask : see_px
  // memory is undefined after reset: every pixel checked is written here first
  task automatic put_at(input logic [3:0] y, input logic [7:0] d);
    host.put(1'b0, {4'h4, y});
    host.put(1'b0, 8'h80);
    host.put(1'b1, d);
  endtask : put_at
  initial begin
    sys_rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    for (int i = 0; i < 12; i++) chk(field(i), rst_exp[i]);
    chk({9'h000, osc_en, bias_gen_en, vlcd_gen_en}, 12'h000);
    foreach (rows[i]) begin
      host.put(rows[i].dc, rows[i].b);
      #1;
      chk(field(rows[i].f), rows[i].e);
    end
    host.put(1'b0, 8'h10);
    host.put(1'b0, 8'h08);
    put_at(4'h0, 8'h80);
    see_px(7'h00, 7'h00, 1'b1);
    host.put(1'b0, 8'h0a);
    see_px(7'h00, 7'h00, 1'b0);
    host.put(1'b0, 8'h14);
    put_at(4'h7, 8'h80);
    see_px(7'h00, 7'h00, 1'b1);
    see_px(7'h00, 7'h07, 1'b0);
    put_at(4'h8, 8'h01);
    see_px(7'h00, 7'h40, 1'b1);
    host.put(1'b0, 8'h0e);
    see_px(7'h00, 7'h20, 1'b1);
    see_px(7'h00, 7'h40, 1'b1);
    chk({11'h000, bank03_col_mode}, 12'h001);
    host.put(1'b0, 8'h18);
    put_at(4'h4, 8'h01);
    see_px(7'h7f, 7'h20, 1'b1);
    host.put(1'b0, 8'h19);
    see_px(7'h7f, 7'h2f, 1'b1);
    chk({10'h000, bias_gen_en, vlcd_gen_en}, 12'h003);
    host.put(1'b0, 8'h24);
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 300; i++) begin
      @(posedge sys_clk);
      #1;
      chk({7'h00, px_out_valid, px_out, osc_en, bias_gen_en, vlcd_gen_en}, 12'h000);
    end
    host.init_pulse();
    #1;
    for (int i = 0; i < 12; i++) chk(field(i), rst_exp[i]);
    give_verdict();
  end
endmodule : lcdr_ctrl_tb
`default_nettype wire
